// File: src/pio_map.svh
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PIO_ADDR_W        4
`define PIO_OFS_CTRL      4'h0
`define PIO_OFS_STAT      4'h4

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define PIO_CTRL_DDR_BIT  0
`define PIO_CTRL_DLAT_BIT 1
`define PIO_CTRL_TLAT_BIT 2
`define PIO_CTRL_SEL_LSB  3
`define PIO_CTRL_INV_BIT  5
`define PIO_CTRL_GBX_BIT  6
`define PIO_CTRL_W        7

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define PIO_STAT_VAL_LSB  0
`define PIO_STAT_EN_LSB   2
`define PIO_STAT_CLK_BIT  4
`define PIO_STAT_CNT_LSB  5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PIO_CTRL_RST      7'h00
`define PIO_RDATA_RST     32'h0000_0000

`endif

// File: src/pio_pkg.sv
package pio_pkg;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      PIO_CLK_ROUTING,
      PIO_CLK_EDGE_A,
      PIO_CLK_EDGE_B,
      PIO_CLK_STROBE
   } pio_clk_src_t;

   // Index 0 is cell A, index 1 the complementary cell B (gearbox only)
   typedef struct packed {
      logic [1:0] out_data_first_phase;
      logic [1:0] out_data_second_phase;
      logic       tri_ctrl_first_phase;
      logic       tri_ctrl_second_phase;
   } pio_word_t;

   typedef struct packed {
      logic         gearbox;
      logic         clk_inv;
      pio_clk_src_t clk_sel;
      logic         tri_latch;
      logic         data_latch;
      logic         ddr;
   } pio_ctrl_t;

endpackage : pio_pkg

// File: src/pio_out_path.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pio_map.svh"

// Notes on behaviour
// RQ1: Core data registered before reaching pad
// RQ2: Single rate: first phase via one element
// RQ3: Single-rate element is flip-flop or latch
// RQ4: Double rate: both phases captured on rise
// RQ5: Second phase latched in following cycle
// RQ6: Clock-driven mux alternates both double-rate paths
// RQ7: Output-enable control registered before pad
// RQ8: Single-rate enable via flip-flop or latch
// RQ9: Double-rate enable: capture, latch, clock mux
// RQ10: Cell pair gearbox takes four streams
// RQ11: Cell clock chosen from four sources
// RQ12: Optional inversion of selected cell clock
// RQ13: Clock high first phase, low second
module pio_out_path (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic [`PIO_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output      logic [31:0]            reg_rdata,
   input  wire logic                   clk_routing,
   input  wire logic                   edge_clock_a,
   input  wire logic                   edge_clock_b,
   input  wire logic                   strobe_clock,
   input  wire logic                   core_valid,
   input  wire pio_pkg::pio_word_t     core_word,
   output      logic                   core_ready,
   output      logic [1:0]             pad_drive_value,
   output      logic [1:0]             pad_drive_en
);
   import pio_pkg::*;

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // -------------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------------
   pio_ctrl_t   ctrl_r;
   pio_ctrl_t   ctrl_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0]  count_r;
   logic        lvl_r;
   logic [1:0]  pad_val_r;
   logic [1:0]  pad_en_r;

   always_comb begin
      ctrl_nxt  = ctrl_r;
      rdata_nxt = `PIO_RDATA_RST;
      if (reg_wr && reg_addr == `PIO_OFS_CTRL) begin
         ctrl_nxt = pio_ctrl_t'(reg_wdata[`PIO_CTRL_W-1:0]);
      end
      if (reg_rd) begin
         case (reg_addr)
            `PIO_OFS_CTRL: begin
               rdata_nxt[`PIO_CTRL_W-1:0] = ctrl_r;
            end
            `PIO_OFS_STAT: begin
               rdata_nxt[`PIO_STAT_VAL_LSB +: 2] = pad_val_r;
               rdata_nxt[`PIO_STAT_EN_LSB +: 2]  = pad_en_r;
               rdata_nxt[`PIO_STAT_CLK_BIT]      = lvl_r;
               rdata_nxt[`PIO_STAT_CNT_LSB +: 2] = count_r;
            end
            default: begin
               rdata_nxt = `PIO_RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_r  <= pio_ctrl_t'(`PIO_CTRL_RST);
         rdata_r <= `PIO_RDATA_RST;
      end else begin
         ctrl_r  <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // -------------------------------------------------------------------
   // Cell clock selection
   // -------------------------------------------------------------------
   // Sources are pins, so each is synchronised before the selector
   logic [3:0] src_pin;
   logic [3:0] src_meta_r;
   logic [3:0] src_sync_r;
   logic       lvl_nxt;
   logic       rise;
   logic       fall;

   assign src_pin = {strobe_clock, edge_clock_b, edge_clock_a, clk_routing};

   generate
      for (genvar i = 0; i < 4; i++) begin : g_src_sync
         always_ff @(posedge sys_clk or negedge rst_sync_r) begin
            if (!rst_sync_r) begin
               src_meta_r[i] <= 1'b0;
               src_sync_r[i] <= 1'b0;
            end else begin
               src_meta_r[i] <= src_pin[i];
               src_sync_r[i] <= src_meta_r[i];
            end
         end
      end
   endgenerate

   always_comb begin
      lvl_nxt = src_sync_r[ctrl_r.clk_sel] ^ ctrl_r.clk_inv;       // see RQ11 see RQ12
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         lvl_r <= 1'b0;
      end else begin
         lvl_r <= lvl_nxt;
      end
   end

   assign rise = lvl_nxt & ~lvl_r;
   assign fall = ~lvl_nxt & lvl_r;

   // -------------------------------------------------------------------
   // Two-entry buffer between core and cell registers
   // -------------------------------------------------------------------
   pio_word_t  buf_r [2];
   pio_word_t  buf_nxt [2];
   logic       wr_ptr_r;
   logic       wr_ptr_nxt;
   logic       rd_ptr_r;
   logic       rd_ptr_nxt;
   logic [1:0] count_nxt;
   logic       push;
   logic       pop;
   logic       head_vld;
   logic       sdr_latch;
   pio_word_t  head;

   assign core_ready = (count_r != 2'd2);
   assign head_vld   = (count_r != 2'd0);
   assign head       = buf_r[rd_ptr_r];
   assign push       = core_valid & core_ready;
   assign sdr_latch  = ~ctrl_r.ddr & (ctrl_r.data_latch | ctrl_r.tri_latch);
   // A latch stays open while the clock is high, so its word leaves at the fall
   assign pop        = head_vld & (sdr_latch ? fall : rise);

   always_comb begin
      buf_nxt    = buf_r;
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt  = count_r;
      if (push) begin
         buf_nxt[wr_ptr_r] = core_word;
         wr_ptr_nxt        = ~wr_ptr_r;
      end
      if (pop) begin
         rd_ptr_nxt = ~rd_ptr_r;
      end
      case ({push, pop})
         2'b10:   count_nxt = count_r + 2'd1;
         2'b01:   count_nxt = count_r - 2'd1;
         default: count_nxt = count_r;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'd0;
      end else begin
         buf_r    <= buf_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Output and tristate storage
   // -------------------------------------------------------------------
   // An empty buffer leaves every element but the second-phase latches holding its last value
   logic [1:0] dneg_r, dneg_nxt;
   logic [1:0] dpos_r, dpos_nxt;
   logic [1:0] dlat_r, dlat_nxt;
   logic       tneg_r, tneg_nxt;
   logic       tpos_r, tpos_nxt;
   logic       tlat_r, tlat_nxt;
   logic       take;

   assign take = head_vld & rise;

   always_comb begin
      dneg_nxt = dneg_r;
      dpos_nxt = dpos_r;
      tneg_nxt = tneg_r;
      tpos_nxt = tpos_r;
      if (ctrl_r.ddr) begin
         if (take) begin
            dneg_nxt = head.out_data_first_phase;                   // see RQ4
            dpos_nxt = head.out_data_second_phase;                  // see RQ4
            tneg_nxt = head.tri_ctrl_first_phase;                   // see RQ9
            tpos_nxt = head.tri_ctrl_second_phase;                  // see RQ9
         end
      end else begin
         if (ctrl_r.data_latch) begin
            if (head_vld && lvl_nxt) begin
               dneg_nxt = head.out_data_first_phase;                // see RQ3
            end
         end else if (take) begin
            dneg_nxt = head.out_data_first_phase;                   // see RQ2 see RQ3
         end
         if (ctrl_r.tri_latch) begin
            if (head_vld && lvl_nxt) begin
               tneg_nxt = head.tri_ctrl_first_phase;                // see RQ8
            end
         end else if (take) begin
            tneg_nxt = head.tri_ctrl_first_phase;                   // see RQ8
         end
      end
      // Second-phase latch is open during the low half after capture
      dlat_nxt = lvl_nxt ? dlat_r : dpos_r;                         // see RQ5
      tlat_nxt = lvl_nxt ? tlat_r : tpos_r;                         // see RQ9
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         dneg_r <= 2'b00;
         dpos_r <= 2'b00;
         dlat_r <= 2'b00;
         tneg_r <= 1'b0;
         tpos_r <= 1'b0;
         tlat_r <= 1'b0;
      end else begin
         dneg_r <= dneg_nxt;                                        // see RQ1
         dpos_r <= dpos_nxt;
         dlat_r <= dlat_nxt;
         tneg_r <= tneg_nxt;                                        // see RQ7
         tpos_r <= tpos_nxt;
         tlat_r <= tlat_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Pad multiplexer and gearbox
   // -------------------------------------------------------------------
   logic [1:0] pad_val_nxt;
   logic [1:0] pad_en_nxt;
   logic [1:0] dsel;
   logic       tsel;

   always_comb begin
      if (ctrl_r.ddr) begin
         dsel = lvl_r ? dneg_r : dlat_r;                            // see RQ6 see RQ13
         tsel = lvl_r ? tneg_r : tlat_r;                            // see RQ9 see RQ13
      end else begin
         dsel = dneg_r;                                             // see RQ2
         tsel = tneg_r;                                             // see RQ8
      end
      pad_val_nxt = 2'b00;
      pad_en_nxt  = 2'b00;
      pad_val_nxt[0] = dsel[0];
      pad_en_nxt[0]  = tsel;
      // Cell B only drives when the pair is ganged as a gearbox
      if (ctrl_r.gearbox) begin
         pad_val_nxt[1] = dsel[1];                                  // see RQ10
         pad_en_nxt[1]  = tsel;                                     // see RQ10
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pad_val_r <= 2'b00;
         pad_en_r  <= 2'b00;
      end else begin
         pad_val_r <= pad_val_nxt;
         pad_en_r  <= pad_en_nxt;
      end
   end

   assign pad_drive_value = pad_val_r;
   assign pad_drive_en    = pad_en_r;

endmodule : pio_out_path

// File: test/pio_out_monitor.sv
`timescale 1ns/1ps
`include "pio_map.svh"
module pio_out_monitor (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        clk_routing,
   input wire logic        edge_clock_a,
   input wire logic        edge_clock_b,
   input wire logic        strobe_clock,
   input wire logic        core_valid,
   input wire logic        core_ready,
   input wire logic [1:0]  pad_drive_value,
   input wire logic [1:0]  pad_drive_en
);
   // ----
   // Helper state
   // ----
   // Pads may move only soon after a pin edge, a push or a setup write
   logic [3:0] pins, pins_r, quiet_r, quiet_nxt;
   logic       gbx_r, gbx_nxt;
   assign pins = {strobe_clock, edge_clock_b, edge_clock_a, clk_routing};
   always_comb begin
      quiet_nxt = (pins != pins_r || reg_wr || core_valid && core_ready) ? 4'h0
                : quiet_r + {3'h0, quiet_r != 4'hf};
      gbx_nxt   = (reg_wr && reg_addr == `PIO_OFS_CTRL) ? reg_wdata[`PIO_CTRL_GBX_BIT] : gbx_r;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_r  <= 4'h0;
         quiet_r <= 4'h0;
         gbx_r   <= 1'b0;
      end else begin
         pins_r  <= pins;
         quiet_r <= quiet_nxt;
         gbx_r   <= gbx_nxt;
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   rdata_width_a: assert property (reg_rdata[31:7] == 25'h0)
      else $error("unused read bits set");
   reset_clear_a: assert property (disable iff (1'b0)
      !rst_n ##1 !rst_n |-> pad_drive_value == 2'h0 && pad_drive_en == 2'h0 && core_ready)
      else $error("outputs not cleared in reset");
   ready_fall_a: assert property ($fell(core_ready) |-> $past(core_valid))
      else $error("ready fell without push");
   quiet_pad_a: assert property (
      quiet_r >= 4'ha |-> $stable(pad_drive_value) && $stable(pad_drive_en))
      else $error("pad moved without cause");
   quiet_ready_a: assert property (quiet_r >= 4'ha |-> $stable(core_ready))
      else $error("ready moved without cause");
   gbx_off_a: assert property (
      (!gbx_r) [*4] |-> pad_drive_value[1] == 1'b0 && pad_drive_en[1] == 1'b0)
      else $error("cell B driven outside gearbox");
   gbx_en_a: assert property (gbx_r [*4] |-> pad_drive_en[1] == pad_drive_en[0])
      else $error("gearbox enables differ");
   cover property (!core_ready);
   cover property (gbx_r && pad_drive_en == 2'h3);
   cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : pio_out_monitor

// File: test/pio_pad_model.sv
`timescale 1ns/1ps
module pio_pad_model (
   input  wire logic [1:0] pad_drive_value,
   input  wire logic [1:0] pad_drive_en,
   output      logic [1:0] pad_line
);
   // A released pad floats to the board pull-up, so a stale value never passes
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pad_line[i] = pad_drive_en[i] ? pad_drive_value[i] : 1'b1;
      end
   end
endmodule : pio_pad_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pio_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        core_valid = 1'b0, core_ready;
   logic [3:0]  reg_addr = 4'h0, src = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [1:0]  pad_drive_value, pad_drive_en, pad_line;
   pio_word_t   core_word = 6'h00;
   int          bad_count, checks_done, cycles;
   pio_out_path dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .clk_routing(src[0]), .edge_clock_a(src[1]), .edge_clock_b(src[2]),
      .strobe_clock(src[3]), .core_valid(core_valid), .core_word(core_word),
      .core_ready(core_ready), .pad_drive_value(pad_drive_value), .pad_drive_en(pad_drive_en));
   pio_pad_model u_pad (.pad_drive_value(pad_drive_value), .pad_drive_en(pad_drive_en),
      .pad_line(pad_line));
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         finish_test();
      end
   end
   // ----
   // Tasks
   // ----
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task finish_test;
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task do_reset;
      rst_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : do_reset
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask : rd
   task push(input pio_word_t w);
      @(posedge sys_clk);
      core_valid <= 1'b1;
      core_word  <= w;
      @(negedge sys_clk);
      while (core_ready !== 1'b1) begin
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      core_valid <= 1'b0;
   endtask : push
   // Pin edges pass two synchronising flops, so allow a generous settle time
   task pin(input int s, input logic v);
      @(posedge sys_clk);
      src[s] <= v;
      repeat (12) @(posedge sys_clk);
   endtask : pin
   task pulse;
      pin(1, 1'b1);
      pin(1, 1'b0);
   endtask : pulse
   task pad(input logic [1:0] v, input logic [1:0] e);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({28'h0, pad_drive_en, pad_drive_value}, {28'h0, e, v});
      chk({30'h0, pad_line}, {30'h0, v | ~e});
   endtask : pad
   task done(input string n);
      $display("test %s ended", n);
   endtask : done
   // ----
   // Tests
   // ----
   initial begin
      do_reset();
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      wr(4'h0, 32'hffff_ffff);
      rd(4'h0, 32'h0000_007f);
      wr(4'h0, 32'h0);
      done("registers");
      wr(4'h0, 32'h0000_0008);
      push(6'h12);
      pad(2'h0, 2'h0);
      pin(1, 1'b1);
      pad(2'h1, 2'h1);
      pin(1, 1'b0);
      pad(2'h1, 2'h1);
      done("single rate flop");
      wr(4'h0, 32'h0000_000e);
      pin(1, 1'b1);
      pad(2'h1, 2'h1);
      push(6'h02);
      pad(2'h0, 2'h1);
      pin(1, 1'b0);
      push(6'h10);
      pad(2'h0, 2'h1);
      pin(1, 1'b1);
      pad(2'h1, 2'h0);
      pin(1, 1'b0);
      done("single rate latch");
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, 32'(1 + 8 * s));
         push(6'h12);
         pin(s, 1'b1);
         pad(2'h1, 2'h1);
         pin(s, 1'b0);
         pad(2'h0, 2'h0);
      end
      done("double rate sources");
      wr(4'h0, 32'h0000_0029);
      push(6'h05);
      pulse();
      pad(2'h0, 2'h0);
      pin(1, 1'b1);
      pad(2'h1, 2'h1);
      pin(1, 1'b0);
      done("inverted clock");
      do_reset();
      wr(4'h0, 32'h0000_0008);
      push(6'h12);
      push(6'h02);
      // Ready is combinational from the count, which moves in this edge's update
      @(negedge sys_clk);
      chk({31'h0, core_ready}, 32'h0);
      rd(4'h4, 32'h0000_0040);
      pulse();
      pad(2'h1, 2'h1);
      push(6'h10);
      pulse();
      pad(2'h0, 2'h1);
      pulse();
      pad(2'h1, 2'h0);
      done("buffer full");
      wr(4'h0, 32'h0000_0049);
      push(6'h27);
      pin(1, 1'b1);
      pad(2'h2, 2'h3);
      rd(4'h4, 32'h0000_001e);
      pin(1, 1'b0);
      pad(2'h1, 2'h3);
      rd(4'h4, 32'h0000_000d);
      done("gearbox");
      finish_test();
   end
endmodule : testbench

bind pio_out_path pio_out_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .clk_routing(clk_routing), .edge_clock_a(edge_clock_a),
   .edge_clock_b(edge_clock_b), .strobe_clock(strobe_clock), .core_valid(core_valid),
   .core_ready(core_ready), .pad_drive_value(pad_drive_value), .pad_drive_en(pad_drive_en));
